// ===== hw/twe_params.svh
// Purpose: Shared constants of the two-wire memory link.
// Assumes: 100 MHz system clock on both ends.
// Notes:   Definitions only.
`ifndef TWE_PARAMS_SVH
`define TWE_PARAMS_SVH
`define TWE_CLK_NS     10
`define TWE_QTR_NS     40
`define TWE_PROG_MS    5
`define TWE_TYPE_CODE  4'ha
`define TWE_AW         15
`define TWE_PW         6
`define TWE_PAGE_BYTES 64
`define TWE_BYTE_BITS  4'h8
`define TWE_FIFO_DEPTH 16
`endif

// ===== hw/twe_pkg.sv
// Purpose: Types shared by both ends of the two-wire memory link.
// Assumes: Constants come from twe_params.svh.
// Notes:   State codes are one-hot.
package twe_pkg;
  typedef enum logic [5:0] {
    TWE_D_IDLE = 6'h01,
    TWE_D_RECV = 6'h02,
    TWE_D_ACK  = 6'h04,
    TWE_D_SEND = 6'h08,
    TWE_D_MACK = 6'h10,
    TWE_D_PROG = 6'h20
  } twe_dstate_e;

  typedef enum logic [4:0] {
    TWE_M_IDLE  = 5'h01,
    TWE_M_START = 5'h02,
    TWE_M_LOAD  = 5'h04,
    TWE_M_BIT   = 5'h08,
    TWE_M_STOP  = 5'h10
  } twe_mstate_e;

  typedef enum logic [1:0] {
    TWE_K_WRITE   = 2'h0,
    TWE_K_READ    = 2'h1,
    TWE_K_RECOVER = 2'h2
  } twe_kind_e;
endpackage : twe_pkg

// ===== hw/twe_bus_if.sv
// Purpose: Open-drain clock and data wires between the two ends.
// Assumes: Both wires are pulled high when nobody drives them low.
// Notes:   A wire is low when any enable is low with its output low.
interface twe_bus_if;
  logic m_scl_o;
  logic m_scl_oe_n;
  logic m_sda_o;
  logic m_sda_oe_n;
  logic d_sda_o;
  logic d_sda_oe_n;
  logic scl;
  logic sda;

  // Wired-AND with pull-up.
  assign scl = m_scl_oe_n | m_scl_o;
  assign sda = (m_sda_oe_n | m_sda_o) & (d_sda_oe_n | d_sda_o);

  modport dev  (input scl, input sda, output d_sda_o, output d_sda_oe_n);
  modport host (input scl, input sda, output m_scl_o, output m_scl_oe_n,
                output m_sda_o, output m_sda_oe_n);
endinterface : twe_bus_if

// ===== hw/twe_dev.sv
// Purpose: Memory end of the two-wire link, 32768 bytes with page writes.
// Assumes: Link wires are sampled by sys_clk, so the link clock must be
//          well below a quarter of the system clock.
// Notes:   The page buffer is committed to the array during programming.
// Notes on behaviour
// - Data moves only while clock low
// - Data falling with clock high is start
// - Data rising with clock high is stop
// - Acknowledge each received byte on ninth clock
// - Standby at reset and after stop
// - Start, nine clocks, start, stop recovers
// - Program time runs from stop after write
// - Device word begins with fixed type code
// - Three select bits must match straps
// - Last device bit: one reads, zero writes
// - Acknowledge on match, else back to standby
// - Write protect high blocks all writes
// - Byte write: device, two address, data
// - Ignore bus while programming
// - Page write takes up to 64 bytes
// - Page writes wrap within the page
// - Polling gets acknowledge only after programming
// - Counter holds last address plus one
// - Current read sends byte at counter
// - Random read uses dummy write first
// - Acknowledged reads continue, wrapping at end
// - 512 pages of 64 bytes, 15-bit address
`include "twe_params.svh"

module twe_dev
  import twe_pkg::*;
#(
  parameter int unsigned PROG_CYCLES =
    `TWE_PROG_MS * 1000000 / `TWE_CLK_NS
) (
  input  wire logic  sys_clk,
  input  wire logic  sys_rst,
  twe_bus_if.dev     bus,
  input  wire logic  chip_select_strap_2,
  input  wire logic  chip_select_strap_1,
  input  wire logic  chip_select_strap_0,
  input  wire logic  write_protect,
  output logic       prog_busy
);

  logic [1:0]           scl_sy;
  logic [1:0]           sda_sy;
  logic                 scl_d;
  logic                 sda_d;
  logic [2:0]           strap_m;
  logic [2:0]           strap_s;
  logic [1:0]           wp_sy;
  logic                 scl_s;
  logic                 sda_s;
  logic                 rise;
  logic                 fall;
  logic                 start_cond;
  logic                 stop_cond;
  twe_dstate_e          st;
  twe_dstate_e          next_st;
  logic [1:0]           role;
  logic [1:0]           next_role;
  logic [3:0]           bcnt;
  logic [3:0]           next_bcnt;
  logic [7:0]           sh;
  logic [7:0]           next_sh;
  logic                 rw;
  logic                 next_rw;
  logic [`TWE_AW-1:0]   cnt;
  logic [`TWE_AW-1:0]   next_cnt;
  logic                 pend;
  logic                 next_pend;
  logic                 oe_n;
  logic                 next_oe_n;
  logic [31:0]          tmr;
  logic [31:0]          next_tmr;
  logic [6:0]           pidx;
  logic [6:0]           next_pidx;
  logic                 pg_we;
  logic                 mem_we;
  logic                 clr_vld;
  logic [7:0]           mem_rd;
  logic [7:0]           mem [0:(1<<`TWE_AW)-1];
  logic [7:0]           pg_buf [0:`TWE_PAGE_BYTES-1];
  logic [`TWE_PAGE_BYTES-1:0] pg_vld;

  // Two flip-flops on every pin before any logic looks at it.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      scl_sy  <= 2'h3;
      sda_sy  <= 2'h3;
      scl_d   <= 1'b1;
      sda_d   <= 1'b1;
      strap_m <= 3'h0;
      strap_s <= 3'h0;
      wp_sy   <= 2'h0;
    end else begin
      scl_sy  <= {scl_sy[0], bus.scl};
      sda_sy  <= {sda_sy[0], bus.sda};
      scl_d   <= scl_sy[1];
      sda_d   <= sda_sy[1];
      strap_m <= {chip_select_strap_2, chip_select_strap_1,
                  chip_select_strap_0};
      strap_s <= strap_m;
      wp_sy   <= {wp_sy[0], write_protect};
    end
  end

  // Edge and condition detection on the synchronised wires.
  assign scl_s      = scl_sy[1];
  assign sda_s      = sda_sy[1];
  assign rise       = scl_s & ~scl_d;
  assign fall       = ~scl_s & scl_d;
  assign start_cond = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_cond  = scl_s & scl_d & ~sda_d & sda_s;
  assign mem_rd     = mem[cnt];
  assign prog_busy  = (st == TWE_D_PROG);
  assign bus.d_sda_o    = 1'b0;
  assign bus.d_sda_oe_n = oe_n;

  // Protocol engine; all bus-side state moves on synchronised edges.
  always_comb begin
    next_st   = st;
    next_role = role;
    next_bcnt = bcnt;
    next_sh   = sh;
    next_rw   = rw;
    next_cnt  = cnt;
    next_pend = pend;
    next_oe_n = oe_n;
    next_tmr  = tmr;
    next_pidx = pidx;
    pg_we     = 1'b0;
    mem_we    = 1'b0;
    clr_vld   = 1'b0;
    case (st)
      TWE_D_IDLE: begin
        next_oe_n = 1'b1;
      end
      TWE_D_RECV: begin
        if (rise) begin
          next_sh   = {sh[6:0], sda_s};
          next_bcnt = bcnt + 4'h1;
        end else if (fall && bcnt == `TWE_BYTE_BITS) begin
          next_bcnt = 4'h0;
          next_st   = TWE_D_ACK;
          next_oe_n = 1'b0;
          case (role)
            2'h0: begin
              if (sh[7:4] == `TWE_TYPE_CODE && sh[3:1] == strap_s) begin
                next_rw   = sh[0];
                next_role = sh[0] ? 2'h0 : 2'h1;
              end else begin
                next_st   = TWE_D_IDLE;
                next_oe_n = 1'b1;
              end
            end
            2'h1: begin
              next_cnt[`TWE_AW-1:8] = sh[6:0];
              next_role = 2'h2;
            end
            2'h2: begin
              next_cnt[7:0] = sh;
              next_role = 2'h3;
            end
            default: begin
              pg_we = ~wp_sy[1];
              if (!wp_sy[1]) begin
                next_pend = 1'b1;
              end
              next_cnt[`TWE_PW-1:0] = cnt[`TWE_PW-1:0] + 6'h1;
            end
          endcase
        end
      end
      TWE_D_ACK: begin
        if (fall) begin
          if (role == 2'h0 && rw) begin
            next_sh   = mem_rd;
            next_cnt  = cnt + 15'h1;
            next_oe_n = mem_rd[7];
            next_st   = TWE_D_SEND;
          end else begin
            next_oe_n = 1'b1;
            next_st   = TWE_D_RECV;
          end
        end
      end
      TWE_D_SEND: begin
        if (rise) begin
          next_bcnt = bcnt + 4'h1;
        end else if (fall) begin
          if (bcnt == `TWE_BYTE_BITS) begin
            next_bcnt = 4'h0;
            next_oe_n = 1'b1;
            next_st   = TWE_D_MACK;
          end else begin
            next_sh   = {sh[6:0], 1'b0};
            next_oe_n = sh[6];
          end
        end
      end
      TWE_D_MACK: begin
        if (rise) begin
          next_bcnt = {3'h0, sda_s}; // Holds the master's answer bit.
        end else if (fall) begin
          next_bcnt = 4'h0;
          if (!bcnt[0]) begin
            next_sh   = mem_rd;
            next_cnt  = cnt + 15'h1;
            next_oe_n = mem_rd[7];
            next_st   = TWE_D_SEND;
          end else begin
            next_st = TWE_D_IDLE;
          end
        end
      end
      TWE_D_PROG: begin
        next_oe_n = 1'b1;
        next_tmr  = tmr + 32'h1;
        if (pidx < 7'(`TWE_PAGE_BYTES)) begin
          mem_we    = pg_vld[pidx[5:0]];
          next_pidx = pidx + 7'h1;
        end
        if (tmr == PROG_CYCLES - 32'h1) begin
          next_st   = TWE_D_IDLE;
          next_pend = 1'b0;
          clr_vld   = 1'b1;
        end
      end
      default: begin
        next_st = TWE_D_IDLE;
      end
    endcase
    // Conditions override the byte engine except while programming.
    if (st != TWE_D_PROG) begin
      if (start_cond) begin
        next_st   = TWE_D_RECV;
        next_role = 2'h0;
        next_bcnt = 4'h0;
        next_oe_n = 1'b1;
      end else if (stop_cond) begin
        next_bcnt = 4'h0;
        next_oe_n = 1'b1;
        next_tmr  = 32'h0;
        next_pidx = 7'h0;
        next_st   = pend ? TWE_D_PROG : TWE_D_IDLE;
      end
    end
  end

  // State registers; the address counter survives between operations.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st   <= TWE_D_IDLE;
      role <= 2'h0;
      bcnt <= 4'h0;
      sh   <= 8'h00;
      rw   <= 1'b0;
      cnt  <= 15'h0000;
      pend <= 1'b0;
      oe_n <= 1'b1;
      tmr  <= 32'h0;
      pidx <= 7'h0;
    end else begin
      st   <= next_st;
      role <= next_role;
      bcnt <= next_bcnt;
      sh   <= next_sh;
      rw   <= next_rw;
      cnt  <= next_cnt;
      pend <= next_pend;
      oe_n <= next_oe_n;
      tmr  <= next_tmr;
      pidx <= next_pidx;
    end
  end

  // Page buffer and array; a late byte of a page overwrites its slot.
  always_ff @(posedge sys_clk) begin
    if (pg_we) begin
      pg_buf[cnt[`TWE_PW-1:0]] <= sh;
    end
    if (mem_we) begin
      mem[{cnt[`TWE_AW-1:`TWE_PW], pidx[5:0]}] <= pg_buf[pidx[5:0]];
    end
  end

  // Valid marks of the page buffer, cleared once programming ends.
  always_ff @(posedge sys_clk) begin
    if (sys_rst || clr_vld) begin
      pg_vld <= '0;
    end else if (pg_we) begin
      pg_vld[cnt[`TWE_PW-1:0]] <= 1'b1;
    end
  end

endmodule : twe_dev

// ===== hw/twe_host.sv
// Purpose: Master end of the two-wire link with a write data FIFO.
// Assumes: One command at a time; the link clock is made by a divider.
// Notes:   A refused device word shows as nack; retry to poll.
`include "twe_params.svh"

module twe_fifo
  import twe_pkg::*;
#(
  parameter int W = 8,
  parameter int D = `TWE_FIFO_DEPTH
) (
  input  wire logic         sys_clk,
  input  wire logic         sys_rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [0:D-1];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0]   cnt;
  logic          push;
  logic          pop;

  // Full and empty come straight from the fill count.
  assign in_ready  = (cnt != (AW+1)'(D));
  assign out_valid = (cnt != '0);
  assign out_data  = mem[rp];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Pointers wrap because the depth is a power of two.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wp  <= '0;
      rp  <= '0;
      cnt <= '0;
    end else begin
      wp  <= wp + AW'(push);
      rp  <= rp + AW'(pop);
      cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Storage needs no reset.
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end
endmodule : twe_fifo

module twe_host
  import twe_pkg::*;
(
  input  wire logic         sys_clk,
  input  wire logic         sys_rst,
  twe_bus_if.host           bus,
  input  wire logic         cmd_valid,
  output logic              cmd_ready,
  input  wire twe_kind_e    cmd_kind,
  input  wire logic [2:0]   cmd_sel,
  input  wire logic [14:0]  cmd_addr,
  input  wire logic [7:0]   cmd_len,
  input  wire logic         wr_valid,
  output logic              wr_ready,
  input  wire logic [7:0]   wr_data,
  output logic              rd_valid,
  output logic [7:0]        rd_data,
  output logic              done,
  output logic              nack
);
  localparam logic [7:0] QTR = 8'(`TWE_QTR_NS / `TWE_CLK_NS);

  twe_mstate_e st;
  twe_mstate_e next_st;
  twe_kind_e   kind;
  twe_kind_e   next_kind;
  logic [1:0]  ph;
  logic [1:0]  next_ph;
  logic [7:0]  qt;
  logic [7:0]  next_qt;
  logic [2:0]  step;
  logic [2:0]  next_step;
  logic [7:0]  left;
  logic [7:0]  next_left;
  logic [2:0]  sel;
  logic [2:0]  next_sel;
  logic [14:0] addr;
  logic [14:0] next_addr;
  logic [8:0]  tx;
  logic [8:0]  next_tx;
  logic [7:0]  rx;
  logic [7:0]  next_rx;
  logic [3:0]  nbit;
  logic [3:0]  next_nbit;
  logic        scl_low;
  logic        next_scl_low;
  logic        sda_low;
  logic        next_sda_low;
  logic        next_rd_valid;
  logic [7:0]  next_rd_data;
  logic        next_done;
  logic        next_nack;
  logic [1:0]  sda_sy;
  logic        tick;
  logic        f_valid;
  logic        f_ready;
  logic [7:0]  f_data;

  twe_fifo #(.W(8), .D(`TWE_FIFO_DEPTH)) twe_fifo_inst (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .in_valid  (wr_valid),
    .in_ready  (wr_ready),
    .in_data   (wr_data),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_data)
  );

  // Wires driven low only through the enables.
  assign bus.m_scl_o    = 1'b0;
  assign bus.m_sda_o    = 1'b0;
  assign bus.m_scl_oe_n = ~scl_low;
  assign bus.m_sda_oe_n = ~sda_low;
  assign cmd_ready      = (st == TWE_M_IDLE);
  assign tick           = (qt == QTR - 8'h1);
  // An empty FIFO holds the clock low, stalling the page write.
  assign f_ready = (st == TWE_M_LOAD) && (kind == TWE_K_WRITE) &&
                   (step == 3'h3) && (left != 8'h00);

  // Sequencer: each bit is four quarter periods of the link clock.
  always_comb begin
    next_st = st; next_kind = kind; next_ph = ph; next_step = step;
    next_left = left; next_sel = sel; next_addr = addr; next_tx = tx;
    next_rx = rx; next_nbit = nbit; next_nack = nack;
    next_qt = (st == TWE_M_IDLE || st == TWE_M_LOAD || tick) ?
              8'h00 : qt + 8'h1;
    next_rd_valid = 1'b0;
    next_rd_data  = rd_data;
    next_done     = 1'b0;
    case (st)
      TWE_M_IDLE: begin
        if (cmd_valid) begin
          next_kind = cmd_kind; next_sel = cmd_sel; next_addr = cmd_addr;
          next_left = cmd_len; next_step = 3'h0; next_ph = 2'h0;
          next_nack = 1'b0;
          next_st   = TWE_M_START;
        end
      end
      TWE_M_START: begin
        if (tick) begin
          next_ph = ph + 2'h1;
          if (ph == 2'h3) begin
            next_st = (kind == TWE_K_RECOVER && step == 3'h2) ?
                      TWE_M_STOP : TWE_M_LOAD;
          end
        end
      end
      TWE_M_LOAD: begin
        next_st = TWE_M_BIT; next_nbit = 4'h0; next_ph = 2'h0;
        next_step = step + 3'h1;
        case (step)
          3'h0: begin
            next_tx = (kind == TWE_K_RECOVER) ? 9'h1ff :
                      {`TWE_TYPE_CODE, sel, 1'b0, 1'b1};
          end
          3'h1: begin
            next_tx = {1'b0, addr[14:8], 1'b1};
            if (kind == TWE_K_RECOVER) begin
              next_st = TWE_M_START;
            end
          end
          3'h2: next_tx = {addr[7:0], 1'b1};
          3'h3: begin
            next_step = step;
            // A read of no bytes ends after the address, so the memory
            // never starts a byte that nobody would clock out.
            if (left == 8'h00) begin
              next_st = TWE_M_STOP;
            end else if (kind == TWE_K_READ) begin
              next_st = TWE_M_START;
              next_step = 3'h4;
            end else if (f_valid) begin
              next_tx = {f_data, 1'b1};
              next_left = left - 8'h1;
            end else begin
              next_st = TWE_M_LOAD;
            end
          end
          3'h4: next_tx = {`TWE_TYPE_CODE, sel, 1'b1, 1'b1};
          default: begin
            next_step = 3'h6; // Data bytes, apart from the read word.
            if (left == 8'h00) begin
              next_st = TWE_M_STOP;
            end else begin
              next_tx = {8'hff, left == 8'h01};
              next_left = left - 8'h1;
            end
          end
        endcase
      end
      TWE_M_BIT: begin
        if (tick) begin
          next_ph = ph + 2'h1;
          if (ph == 2'h3) begin
            next_tx = {tx[7:0], 1'b1}; next_nbit = nbit + 4'h1;
            next_st = TWE_M_LOAD; next_ph = 2'h0;
            if (nbit != `TWE_BYTE_BITS) begin
              next_rx = {rx[6:0], sda_sy[1]};
              next_st = TWE_M_BIT;
            end else if (kind == TWE_K_READ && step == 3'h6) begin
              next_rd_valid = 1'b1;
              next_rd_data  = rx;
            end else if (kind != TWE_K_RECOVER && sda_sy[1]) begin
              next_nack = 1'b1;
              next_st   = TWE_M_STOP;
            end
          end
        end
      end
      TWE_M_STOP: begin
        if (tick) begin
          next_ph = ph + 2'h1;
          if (ph == 2'h3) begin
            next_st = TWE_M_IDLE; next_done = 1'b1;
          end
        end
      end
      default: next_st = TWE_M_IDLE;
    endcase
    // Wire levels; data only moves while the clock is low, except at start and stop.
    case (st)
      TWE_M_START: begin
        next_scl_low = (ph == 2'h0); next_sda_low = ph[1];
      end
      TWE_M_LOAD: begin
        next_scl_low = 1'b1; next_sda_low = sda_low;
      end
      TWE_M_BIT: begin
        next_scl_low = ~ph[1]; next_sda_low = ~tx[8];
      end
      TWE_M_STOP: begin
        next_scl_low = ~ph[1]; next_sda_low = (ph != 2'h3);
      end
      default: begin
        next_scl_low = 1'b0; next_sda_low = 1'b0;
      end
    endcase
  end

  // Registers, plus a two-stage synchroniser on the data wire.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st <= TWE_M_IDLE; kind <= TWE_K_WRITE; ph <= 2'h0; qt <= 8'h00;
      step <= 3'h0; left <= 8'h00; sel <= 3'h0; addr <= 15'h0000;
      tx <= 9'h1ff; rx <= 8'h00; nbit <= 4'h0; scl_low <= 1'b0;
      sda_low <= 1'b0; rd_valid <= 1'b0; rd_data <= 8'h00;
      done <= 1'b0; nack <= 1'b0; sda_sy <= 2'h3;
    end else begin
      st <= next_st; kind <= next_kind; ph <= next_ph; qt <= next_qt;
      step <= next_step; left <= next_left; sel <= next_sel;
      addr <= next_addr; tx <= next_tx; rx <= next_rx; nbit <= next_nbit;
      scl_low <= next_scl_low; sda_low <= next_sda_low;
      rd_valid <= next_rd_valid; rd_data <= next_rd_data;
      done <= next_done; nack <= next_nack;
      sda_sy <= {sda_sy[0], bus.sda};
    end
  end
endmodule : twe_host

// ===== tb/twe_bus_sva.sv
// Purpose: Wire-level checks on the two-wire memory link.
// Assumes: Link wires are sampled by sys_clk, link clock far below it.
// Notes:   Instantiated beside the link interface in the bench.
module twe_bus_sva #(
  parameter int unsigned PROG_CYCLES = 400
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic m_scl_oe_n,
  input wire logic d_sda_oe_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic prog_busy
);
  timeunit 1ns;
  timeprecision 100ps;
  int unsigned busy_cnt;
  int unsigned next_busy_cnt;

  // Counts programming cycles so the length is judged when busy drops.
  always_comb begin
    next_busy_cnt = prog_busy ? busy_cnt + 1 : 0;
  end

  always_ff @(posedge sys_clk) begin
    busy_cnt <= sys_rst ? 0 : next_busy_cnt;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // Pull-ups alone set the wires, so the device must never drive early.
  chk_rst_released: assert property ($fell(sys_rst) |->
    d_sda_oe_n && m_scl_oe_n && !prog_busy) else $error("wires held");
  chk_dev_after_fall: assert property ($changed(d_sda_oe_n) |->
    !scl && $past(!scl)) else $error("device moved sda near scl rise");
  chk_dev_hold_high: assert property (scl && $past(scl) |->
    $stable(d_sda_oe_n)) else $error("device moved sda with scl high");
  chk_busy_no_ack: assert property (prog_busy |-> d_sda_oe_n)
    else $error("device drove sda while programming");
  chk_busy_after_stop: assert property ($rose(prog_busy) |->
    scl && sda) else $error("programming began without stop");
  chk_busy_length: assert property ($fell(prog_busy) |->
    busy_cnt >= PROG_CYCLES && busy_cnt <= PROG_CYCLES + 1)
    else $error("programming length wrong");
  chk_stop_standby: assert property (scl && $rose(sda) |=>
    d_sda_oe_n [*8]) else $error("device active after stop");
  chk_start_released: assert property (scl && $fell(sda) |=>
    d_sda_oe_n [*8]) else $error("device drove sda after start");
  chk_host_clk_high: assert property ($rose(m_scl_oe_n) |=>
    m_scl_oe_n [*7]) else $error("link clock high phase short");

  cover property ($rose(prog_busy));
  cover property (scl && $rose(sda));
  cover property ($fell(d_sda_oe_n));
endmodule : twe_bus_sva

// ===== tb/tb_two_wire_eeprom_slave.sv
// Purpose: Self-checking bench joining host and memory ends.
// Assumes: Straps tied to select 2; host makes the 160 ns link clock.
// Notes:   Programming time shortened so polling loops stay brief.
module tb_two_wire_eeprom_slave
  import twe_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned PROG = 400;
  logic        sys_clk;
  logic        sys_rst;
  logic        write_protect;
  logic        prog_busy;
  logic        cmd_valid;
  logic        cmd_ready;
  twe_kind_e   cmd_kind;
  logic [2:0]  cmd_sel;
  logic [14:0] cmd_addr;
  logic [7:0]  cmd_len;
  logic        wr_valid;
  logic        wr_ready;
  logic [7:0]  wr_data;
  logic        rd_valid;
  logic [7:0]  rd_data;
  logic        done;
  logic        nack;
  logic [7:0]  rdq[$];
  int          mismatches;
  int          n_compared;
  int          cycles;

  twe_bus_if twe_bus_if_inst ();
  twe_dev #(.PROG_CYCLES(PROG)) twe_dev_inst (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .bus(twe_bus_if_inst), .chip_select_strap_2(1'b0),
    .chip_select_strap_1(1'b1), .chip_select_strap_0(1'b0),
    .write_protect(write_protect), .prog_busy(prog_busy));
  twe_host twe_host_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .bus(twe_bus_if_inst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_kind(cmd_kind), .cmd_sel(cmd_sel), .cmd_addr(cmd_addr),
    .cmd_len(cmd_len), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_data(wr_data), .rd_valid(rd_valid), .rd_data(rd_data),
    .done(done), .nack(nack));
  twe_bus_sva #(.PROG_CYCLES(PROG)) twe_bus_sva_inst (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .m_scl_oe_n(twe_bus_if_inst.m_scl_oe_n),
    .d_sda_oe_n(twe_bus_if_inst.d_sda_oe_n), .scl(twe_bus_if_inst.scl),
    .sda(twe_bus_if_inst.sda), .prog_busy(prog_busy));

  // Clock, and a cycle limit that cuts a hung run short.
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 80000) begin
      mismatches++;
      final_report();
    end
  end
  // Read bytes are collected at the falling edge, where they are settled.
  always @(negedge sys_clk) begin
    if (rd_valid === 1'b1) rdq.push_back(rd_data);
  end

  task automatic chk_byte(input string nm, input logic [7:0] e,
                          input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_byte

  task automatic chk_flag(input string nm, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_flag

  // One command, held for one cycle, then waited on under a bound.
  task automatic run_cmd(input twe_kind_e k, input logic [2:0] s,
                         input logic [14:0] a, input logic [7:0] n);
    int t;
    rdq.delete();
    @(negedge sys_clk);
    cmd_valid = 1'b1;
    cmd_kind  = k;
    cmd_sel   = s;
    cmd_addr  = a;
    cmd_len   = n;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    for (t = 0; t < 20000 && done !== 1'b1; t++) @(negedge sys_clk);
    chk_flag("done", 1'b1, done);
    chk_flag("ready", 1'b1, cmd_ready);
  endtask : run_cmd

  task automatic push(input logic [7:0] b);
    @(negedge sys_clk);
    wr_valid = 1'b1;
    wr_data  = b;
    @(negedge sys_clk);
    wr_valid = 1'b0;
  endtask : push

  // Retries are needed because a busy device refuses its device word.
  task automatic poll();
    for (int i = 0; i < 10; i++) begin
      run_cmd(TWE_K_READ, 3'h2, 15'h0000, 8'h00);
      if (nack === 1'b0) break;
    end
    chk_flag("poll nack", 1'b0, nack);
  endtask : poll

  task automatic wr_byte(input logic [14:0] a, input logic [7:0] d);
    push(d);
    run_cmd(TWE_K_WRITE, 3'h2, a, 8'h01);
    chk_flag("write nack", 1'b0, nack);
    poll();
  endtask : wr_byte

  task automatic t_select();
    run_cmd(TWE_K_READ, 3'h5, 15'h0000, 8'h00);
    chk_flag("wrong select", 1'b1, nack);
    run_cmd(TWE_K_READ, 3'h2, 15'h0000, 8'h00);
    chk_flag("right select", 1'b0, nack);
  endtask : t_select

  // Sixteen bytes from offset 56 must wrap to the page start.
  task automatic t_page();
    for (int i = 0; i < 16; i++) begin
      @(negedge sys_clk);
      wr_valid = 1'b1;
      wr_data  = 8'ha0 + 8'(i);
    end
    @(negedge sys_clk);
    wr_valid = 1'b0;
    chk_flag("fifo full", 1'b0, wr_ready);
    run_cmd(TWE_K_WRITE, 3'h2, 15'h0038, 8'h10);
    chk_flag("page nack", 1'b0, nack);
    chk_flag("fifo drained", 1'b1, wr_ready);
    run_cmd(TWE_K_READ, 3'h2, 15'h0000, 8'h00);
    chk_flag("busy nack", 1'b1, nack);
    poll();
    run_cmd(TWE_K_READ, 3'h2, 15'h0038, 8'h08);
    for (int i = 0; i < 8; i++) begin
      chk_byte("page tail", 8'ha0 + 8'(i), rdq[i]);
    end
    run_cmd(TWE_K_READ, 3'h2, 15'h0000, 8'h08);
    for (int i = 0; i < 8; i++) begin
      chk_byte("page head", 8'ha8 + 8'(i), rdq[i]);
    end
  endtask : t_page

  task automatic t_protect();
    wr_byte(15'h0100, 8'h11);
    write_protect = 1'b1;
    push(8'h5c);
    run_cmd(TWE_K_WRITE, 3'h2, 15'h0100, 8'h01);
    chk_flag("wp nack", 1'b0, nack);
    chk_flag("wp busy", 1'b0, prog_busy);
    write_protect = 1'b0;
    run_cmd(TWE_K_RECOVER, 3'h2, 15'h0000, 8'h00);
    run_cmd(TWE_K_READ, 3'h2, 15'h0100, 8'h01);
    chk_byte("wp kept", 8'h11, rdq[0]);
  endtask : t_protect

  // Reading past the top address must continue at address zero.
  task automatic t_wrap();
    wr_byte(15'h7fff, 8'h3c);
    run_cmd(TWE_K_READ, 3'h2, 15'h7fff, 8'h02);
    chk_byte("last byte", 8'h3c, rdq[0]);
    chk_byte("wrapped", 8'ha8, rdq[1]);
  endtask : t_wrap

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report

  initial begin
    sys_rst = 1'b1;
    write_protect = 1'b0;
    cmd_valid = 1'b0;
    cmd_kind = TWE_K_WRITE;
    cmd_sel = 3'h0;
    cmd_addr = 15'h0000;
    cmd_len = 8'h00;
    wr_valid = 1'b0;
    wr_data = 8'h00;
    repeat (8) @(negedge sys_clk);
    sys_rst = 1'b0;
    t_select();
    t_page();
    t_protect();
    t_wrap();
    final_report();
  end
endmodule : tb_two_wire_eeprom_slave
